//--- core/fpm_pkg.sv
// shared constants and carriers of the process-data mapper
// assumes one 40 MHz clock domain, synchronous active-low reset
package fpm_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned BAUD          = 57_600;
   localparam int unsigned BAUD_DIV      = CLK_HZ / BAUD;
   // least output periods per mode, in ms
   localparam int unsigned PER_M1_MS     = 12;
   localparam int unsigned PER_M2_MS     = 17;
   localparam int unsigned PER_M3_MS     = 17;
   localparam int unsigned PER_M4_MS     = 15;
   localparam int unsigned PER_M5_MS     = 20;
   localparam int unsigned PER_M6_MS     = 30;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   // image lengths in bytes per mode
   localparam logic [3:0]  LEN_M1        = 4'h8;
   localparam logic [3:0]  LEN_M2        = 4'h0; // 16 wraps to 0
   localparam logic [3:0]  LEN_M3        = 4'hA;
   localparam logic [3:0]  LEN_M4        = 4'hC;
   localparam logic [3:0]  LEN_M5        = 4'hE;
   localparam logic [3:0]  LEN_M6        = 4'hF;
   // control byte fields
   localparam int unsigned CB_STBY_ALT   = 0;
   localparam int unsigned CB_DIR        = 1;
   localparam int unsigned CB_STBY_TRIGGER_TWO  = 2;
   localparam int unsigned CB_TRI1       = 3;
   localparam int unsigned CB_CLEAR      = 4;
   localparam int unsigned CB_SET_LO     = 5;
   localparam int unsigned CB_RESTORE    = 7;
   // status byte fields
   localparam int unsigned ST_ERR        = 0;
   localparam int unsigned ST_SIG        = 1;
   localparam int unsigned ST_VSIGN      = 2;
   localparam int unsigned ST_LSIGN      = 3;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [2:0]  MODE_RST      = 3'h1;

   typedef struct packed {
      logic [15:0] counter;
      logic        velNeg;
      logic [31:0] velocity;   // 0.00001 m/s
      logic [15:0] rate;       // 0.1 %
      logic [31:0] integral;
      logic [31:0] msTimer;
      logic        lenNeg;
      logic [47:0] length;     // 0.0001 m, internal range wider
      logic [7:0]  illum;
      logic [7:0]  exposure;
      logic [7:0]  errCode;
      logic        sigOk;
      logic        errFlag;
      logic [7:0]  temp;
   } fpm_meas_s;

   typedef struct packed {
      logic       standby;
      logic       direction;
      logic       trigOne;
      logic       trigTwo;
      logic       clearErr;   // one-cycle pulse
      logic       restore;    // one-cycle pulse
      logic [1:0] paramSet;
   } fpm_ctl_s;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_LOAD  = 4'b0100,
      ST_SEND  = 4'b1000
   } fpm_state_e;
endpackage : fpm_pkg

//--- core/fpm_fifo.sv
// byte fifo between image builder and serial transmitter
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
module fpm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,     // clock
   input  wire logic             rst_b,   // sync reset, low
   input  wire logic             ce,      // clock enable
   input  wire logic [WIDTH-1:0] inData,  // write data
   input  wire logic             inValid, // write request
   output logic                  inReady, // space left
   output logic      [WIDTH-1:0] outData, // head word
   output logic                  outValid,// not empty
   input  wire logic             outReady // reader takes head
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem[rdPtr_q];

   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else if (ce) begin
         if (push) wrPtr_q <= wrPtr_q + 1'b1;
         if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
         if (push && !pop) count_q <= count_q + 1'b1;
         else if (pop && !push) count_q <= count_q - 1'b1;
      end
   end
endmodule : fpm_fifo

//--- core/fpm_mapper.sv
// process-data mapper: builds cyclic input image, decodes control byte,
// and sends the image most significant byte first over an 8N1 serial line.
// assumes measurements arrive as a struct from the sensor core.
`timescale 1ns/100ps
// What this block does
// RULE1 - mode 1 image: counter, velocity, rate; period at least 12 ms
// RULE2 - mode 2 adds velocity integral and ms timer; period 17 ms
// RULE3 - mode 3 adds illumination and exposure; mode 5 after length
// RULE4 - mode 4 adds 32-bit length; period at least 15 ms
// RULE5 - mode 6 adds length, error code, status, temperature; 30 ms
// RULE6 - velocity 0.00001 m/s, length 0.0001 m, rate 0.1 percent units
// RULE7 - multi-byte fields are magnitudes, most significant byte first
// RULE8 - sent length wraps at 32 bits; internal count keeps going
// RULE9 - velocity always unsigned; direction only in mode 6 status
// RULE10 - status: length sign, velocity sign, signal, error bits
// RULE11 - control bit 1 drives measurement direction
// RULE12 - bit 3 is trigger one; bit 2 standby or trigger two
// RULE13 - rising edge of control bit 4 clears error data once
// RULE14 - bits 6:5 select parameter set; bit 7 starts restore
// RULE15 - controller returns bit 7 to zero after restore request
// RULE16 - bit 2 high requests standby; device enters standby
// RULE17 - with trigger-select set, bit 0 requests standby instead
// RULE18 - sensor format setting must match the chosen mode
// RULE19 - internal serial link enabled at 57600 baud, no parity
// RULE20 - output continuous at period or on trigger events
// RULE21 - fields packed contiguously from first image byte
module fpm_mapper
   import fpm_pkg::*;
(
   input  wire logic             clk,          // 40 MHz clock
   input  wire logic             rst_b,        // sync reset, low
   input  wire logic             ce,           // clock enable
   input  wire logic [2:0]       modeSel,      // mode 1..6
   input  wire logic             triggerSel,   // trigger-select param
   input  wire logic             serialOutputSync, // trigger-synchronous
   input  wire logic [7:0]       ctrlIn,       // control byte from bus
   input  wire logic             ctrlWe,       // control byte strobe
   input  wire fpm_pkg::fpm_meas_s meas,       // current measurement
   output fpm_pkg::fpm_ctl_s     ctl,          // decoded actions
   output logic [7:0]            controlByte,  // control byte readback
   output logic [7:0]            deviceStatusByte, // status byte
   output logic [7:0]            imgData,      // image byte
   output logic                  imgValid,     // image byte strobe
   output logic                  imgLast,      // last byte of image
   output logic                  serialTx      // internal serial line
);
   import fpm_pkg::*;

   logic [7:0]   ctrl_q;
   logic         clrPrev_q;
   logic         restPrev_q;
   fpm_ctl_s     ctl_q;
   fpm_state_e   state_q;
   logic [31:0]  perCnt_q;
   logic [31:0]  perLim;
   logic [3:0]   imgLen;
   logic [3:0]   byteIdx_q;
   logic [127:0] image_q;
   logic [127:0] imageNow;
   logic [7:0]   statusNow;
   logic [7:0]   status_q;
   logic         lastByte;
   logic         sendByte;
   logic         baudTick;
   logic         trigSeen;
   logic         trigPrev_q;
   logic         fifoInReady;
   logic [7:0]   fifoOut;
   logic         fifoOutValid;
   logic         txTake;
   logic [9:0]   txShift_q;
   logic [3:0]   txBits_q;
   logic [15:0]  baudCnt_q;
   logic [7:0]   imgData_q;
   logic         imgValid_q;
   logic         imgLast_q;

   // control byte register
   always_ff @(posedge clk) begin
      if (!rst_b) ctrl_q <= CTRL_RST;
      else if (ce && ctrlWe) ctrl_q <= ctrlIn;
   end
   assign controlByte = ctrl_q;

   // earlier levels of the edge-triggered bits; they reset to 0 so a
   // bit set by the first write after reset counts as a rise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clrPrev_q  <= 1'b0;
         restPrev_q <= 1'b0;
      end else if (ce) begin
         clrPrev_q  <= ctrl_q[CB_CLEAR];
         restPrev_q <= ctrl_q[CB_RESTORE];
      end
   end

   // actions follow the register one cycle later
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctl_q <= '0;
      end else if (ce) begin
         ctl_q.direction <= ctrl_q[CB_DIR]; // RULE11
         ctl_q.trigOne   <= ctrl_q[CB_TRI1]; // RULE12
         // RULE16 RULE17 bit 2 is standby unless trigger-select moves it
         ctl_q.standby   <= triggerSel ? ctrl_q[CB_STBY_ALT]
                                       : ctrl_q[CB_STBY_TRIGGER_TWO];
         ctl_q.trigTwo   <= triggerSel & ctrl_q[CB_STBY_TRIGGER_TWO]; // RULE12
         ctl_q.clearErr  <= ctrl_q[CB_CLEAR] & ~clrPrev_q; // RULE13
         ctl_q.paramSet  <= ctrl_q[CB_SET_LO+1:CB_SET_LO]; // RULE14
         // restore fires once per set; the controller must drop bit 7
         ctl_q.restore   <= ctrl_q[CB_RESTORE] & ~restPrev_q; // RULE14 RULE15
      end
   end
   assign ctl = ctl_q;

   // RULE10 RULE9 signs live only in the status byte
   assign statusNow = {4'h0, meas.lenNeg, meas.velNeg,
                       meas.sigOk, meas.errFlag};
   // registered so the fieldbus side reads a settled byte; it lags
   // the measurement by one cycle
   always_ff @(posedge clk) begin
      if (!rst_b) status_q <= '0;
      else if (ce) status_q <= statusNow; // RULE10
   end
   assign deviceStatusByte = status_q;

   // RULE21 RULE7 RULE6 left-justified big-endian image; values are
   // already magnitudes in the documented units from the sensor core
   always_comb begin
      imageNow = '0;
      unique case (modeSel)
         3'd2: imageNow = {meas.counter, meas.velocity, meas.rate,
                           meas.integral, meas.msTimer}; // RULE2
         3'd3: imageNow = {meas.counter, meas.velocity, meas.rate,
                           meas.illum, meas.exposure, 48'h0}; // RULE3
         3'd4: imageNow = {meas.counter, meas.velocity, meas.rate,
                           meas.length[31:0], 32'h0}; // RULE4 RULE8
         3'd5: imageNow = {meas.counter, meas.velocity, meas.rate,
                           meas.length[31:0], meas.illum,
                           meas.exposure, 16'h0}; // RULE3 RULE8
         3'd6: imageNow = {meas.counter, meas.velocity, meas.rate,
                           meas.length[31:0], meas.errCode,
                           statusNow, meas.temp, 8'h0}; // RULE5
         default: imageNow = {meas.counter, meas.velocity, meas.rate,
                              64'h0}; // RULE1
      endcase
   end

   always_comb begin
      perLim = 32'(PER_M1_MS * CYC_PER_MS);
      imgLen = LEN_M1;
      unique case (modeSel)
         3'd2: begin
            perLim = 32'(PER_M2_MS * CYC_PER_MS); // RULE2
            imgLen = LEN_M2;
         end
         3'd3: begin
            perLim = 32'(PER_M3_MS * CYC_PER_MS); // RULE3
            imgLen = LEN_M3;
         end
         3'd4: begin
            perLim = 32'(PER_M4_MS * CYC_PER_MS); // RULE4
            imgLen = LEN_M4;
         end
         3'd5: begin
            perLim = 32'(PER_M5_MS * CYC_PER_MS); // RULE3
            imgLen = LEN_M5;
         end
         3'd6: begin
            perLim = 32'(PER_M6_MS * CYC_PER_MS); // RULE5
            imgLen = LEN_M6;
         end
         default: begin
            perLim = 32'(PER_M1_MS * CYC_PER_MS); // RULE1
            imgLen = LEN_M1;
         end
      endcase
   end

   // the OR of both trigger inputs rising counts as an event; a level held
   // high gives only one event
   always_ff @(posedge clk) begin
      if (!rst_b) trigPrev_q <= 1'b0;
      else if (ce) trigPrev_q <= ctl_q.trigOne | ctl_q.trigTwo;
   end
   assign trigSeen = (ctl_q.trigOne | ctl_q.trigTwo) & ~trigPrev_q;

   // mode 2 is 16 bytes: its length code wraps to 0 in four bits, so
   // the compare is kept four bits wide on purpose
   assign lastByte = (byteIdx_q + 4'h1) == imgLen;
   assign sendByte = (state_q == ST_SEND) && fifoInReady;

   // period counter; it still runs in triggered mode so that triggers
   // never come faster than the least period; counted from the load
   // state, so frames are at least perLim + 1 cycles apart
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         perCnt_q <= '0;
      end else if (ce) begin
         if (state_q == ST_LOAD) begin
            perCnt_q <= perLim - 32'h1;
         end else if (perCnt_q != '0) begin
            perCnt_q <= perCnt_q - 32'h1;
         end
      end
   end

   // frame sequencer; a frame under way completes even in standby
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
      end else if (ce) begin
         unique case (state_q)
            ST_IDLE: begin
               if (!ctl_q.standby) state_q <= ST_WAIT; // RULE16
            end
            ST_WAIT: begin
               if (ctl_q.standby) begin
                  state_q <= ST_IDLE; // RULE16
               end else if (perCnt_q == '0 &&
                            (!serialOutputSync || trigSeen)) begin // RULE20
                  state_q <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               state_q <= ST_SEND;
            end
            ST_SEND: begin
               if (sendByte && lastByte) state_q <= ST_WAIT;
            end
         endcase
      end
   end

   // byte index within the frame under way
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         byteIdx_q <= '0;
      end else if (ce) begin
         if (state_q == ST_LOAD) begin
            byteIdx_q <= '0;
         end else if (sendByte) begin
            byteIdx_q <= byteIdx_q + 4'h1;
         end
      end
   end

   // RULE7 the top byte of the shifter is always the next one out;
   // spare low bytes stay zero and are never sent
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         image_q <= '0;
      end else if (ce) begin
         if (state_q == ST_LOAD) begin
            image_q <= imageNow;
         end else if (sendByte) begin
            image_q <= {image_q[119:0], 8'h00};
         end
      end
   end

   // image bytes towards the fieldbus controller; a byte is shown
   // only when the fifo took it, so both sides see the same stream
   always_ff @(posedge clk) begin
      if (!rst_b) imgValid_q <= 1'b0;
      else if (ce) imgValid_q <= sendByte;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) imgData_q <= '0;
      else if (ce) imgData_q <= image_q[127:120]; // RULE7
   end

   always_ff @(posedge clk) begin
      if (!rst_b) imgLast_q <= 1'b0;
      else if (ce) imgLast_q <= sendByte && lastByte; // RULE21
   end
   assign imgData  = imgData_q;
   assign imgValid = imgValid_q;
   assign imgLast  = imgLast_q;

   // the fifo lets the image go out at one byte a cycle while the
   // serial line drains it; a full fifo holds the sequencer in send
   fpm_fifo #(
      .WIDTH (8),
      .DEPTH (16)
   ) u_fifo (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .inData   (image_q[127:120]),
      .inValid  (state_q == ST_SEND),
      .inReady  (fifoInReady),
      .outData  (fifoOut),
      .outValid (fifoOutValid),
      .outReady (txTake)
   );

   // RULE19 8N1 transmitter at 57600 baud, stalls the fifo while busy
   assign txTake   = fifoOutValid && (txBits_q == '0);
   assign baudTick = (txBits_q != '0) && (baudCnt_q == '0);

   // stop bit and idle both shift in ones, so the line rests high
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         txShift_q <= 10'h3FF;
      end else if (ce) begin
         if (txTake) begin
            txShift_q <= {1'b1, fifoOut, 1'b0};
         end else if (baudTick) begin
            txShift_q <= {1'b1, txShift_q[9:1]};
         end
      end
   end

   // bits left in the frame, start and stop included
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         txBits_q <= '0;
      end else if (ce) begin
         if (txTake) begin
            txBits_q <= 4'hA;
         end else if (baudTick) begin
            txBits_q <= txBits_q - 4'h1;
         end
      end
   end

   // the divider rounds down, so each bit is a little short of nominal,
   // well inside what an ordinary receiver accepts
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         baudCnt_q <= '0;
      end else if (ce) begin
         if (txTake || baudTick) begin
            baudCnt_q <= 16'(BAUD_DIV - 1);
         end else if (txBits_q != '0) begin
            baudCnt_q <= baudCnt_q - 16'h1;
         end
      end
   end
   assign serialTx = txShift_q[0]; // RULE19
endmodule : fpm_mapper

//--- test/fpm_mapper_monitor.sv
// concurrent checks on the ports of the process-data mapper
// assumes one clock and a sync active-low reset; bound at the foot
`timescale 1ns/100ps
module fpm_mapper_monitor (
   input wire logic               clk,              // clock
   input wire logic               rst_b,            // sync reset, low
   input wire logic               ce,               // clock enable
   input wire logic [2:0]         modeSel,          // mode
   input wire logic               triggerSel,       // standby select
   input wire logic               serialOutputSync, // triggered output
   input wire logic [7:0]         ctrlIn,           // control data
   input wire logic               ctrlWe,           // control write
   input wire fpm_pkg::fpm_meas_s meas,             // measurement
   input wire fpm_pkg::fpm_ctl_s  ctl,              // decoded actions
   input wire logic [7:0]         controlByte,      // readback
   input wire logic [7:0]         deviceStatusByte, // status byte
   input wire logic [7:0]         imgData,          // image byte
   input wire logic               imgValid,         // image strobe
   input wire logic               imgLast,          // last byte
   input wire logic               serialTx          // serial line
);
   import fpm_pkg::*;
   int unsigned cnt;
   logic        live;
   logic        ts1;
   logic        ts2;
   logic        tsSteady;
   function automatic int unsigned lenOf(logic [2:0] m);
      case (m)
         3'h2: return 16;
         3'h3: return 10;
         3'h4: return 12;
         3'h5: return 14;
         3'h6: return 15;
         default: return 8;
      endcase
   endfunction : lenOf
   always_ff @(posedge clk) begin
      if (!rst_b || imgLast)
         cnt <= 0;
      else if (imgValid)
         cnt <= cnt + 1;
   end
   // decode checks only where the previous edge really updated ctl
   always_ff @(posedge clk) begin
      live <= rst_b && ce;
      ts1 <= triggerSel;
      ts2 <= ts1;
   end
   assign tsSteady = (triggerSel == ts1) && (ts1 == ts2);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_status_bits: assert property (
      live |-> deviceStatusByte == $past({4'h0, meas.lenNeg, meas.velNeg,
                                          meas.sigOk, meas.errFlag}))
      else $error("status byte layout wrong");
   a_readback_echo: assert property (
      ctrlWe && ce |=> controlByte == $past(ctrlIn))
      else $error("control readback wrong");
   a_dir_follow: assert property (
      live |-> ctl.direction == $past(controlByte[1]))
      else $error("direction not from bit 1");
   a_trig_one: assert property (
      live |-> ctl.trigOne == $past(controlByte[3]))
      else $error("trigger one not from bit 3");
   a_standby_pick: assert property (
      live && tsSteady |-> ctl.standby ==
         (triggerSel ? $past(controlByte[0]) : $past(controlByte[2])))
      else $error("standby from wrong bit");
   a_trig_two: assert property (
      live && tsSteady |-> ctl.trigTwo ==
         (triggerSel && $past(controlByte[2])))
      else $error("trigger two wrong");
   a_param_set: assert property (
      live |-> ctl.paramSet == $past(controlByte[6:5]))
      else $error("parameter set number wrong");
   a_clear_pulse: assert property (
      $rose(controlByte[4]) |=> ctl.clearErr ##1 !ctl.clearErr)
      else $error("error clear not a single pulse");
   a_restore_pulse: assert property (
      $rose(controlByte[7]) |=> ctl.restore ##1 !ctl.restore)
      else $error("restore not a single pulse");
   a_frame_len: assert property (
      imgLast |-> imgValid && cnt + 1 == lenOf(modeSel))
      else $error("image length wrong for mode");
   c_long_frame: cover property (imgLast && modeSel == 3'h2);
   c_clear: cover property (ctl.clearErr);
   c_standby_alt: cover property (ctl.standby && triggerSel);
endmodule : fpm_mapper_monitor

bind fpm_mapper fpm_mapper_monitor mon (.clk, .rst_b, .ce, .modeSel,
   .triggerSel, .serialOutputSync, .ctrlIn, .ctrlWe, .meas, .ctl,
   .controlByte, .deviceStatusByte, .imgData, .imgValid, .imgLast,
   .serialTx);

//--- test/fpm_serial_rx.sv
// serial receiver standing at the far end of the mapper's line
// assumes 8N1 framing, idle high, BAUD_DIV clocks per bit
`timescale 1ns/100ps
module fpm_serial_rx (
   input  wire logic  clk,     // clock
   input  wire logic  rst_b,   // sync reset, low
   input  wire logic  rxLine,  // line from the mapper
   output logic [7:0] rxByte,  // last received byte
   output logic       rxStrobe // one cycle per good byte
);
   import fpm_pkg::*;
   int         cnt;
   int         bitNo;
   logic [7:0] sh;
   always_ff @(posedge clk) begin
      rxStrobe <= 1'b0;
      if (!rst_b) begin
         bitNo <= -1;
         cnt <= 0;
      end else if (bitNo < 0) begin
         // first sample lands mid first data bit
         if (!rxLine) begin
            bitNo <= 0;
            cnt <= 3 * BAUD_DIV / 2;
         end
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end else if (bitNo < 8) begin
         sh <= {rxLine, sh[7:1]};
         bitNo <= bitNo + 1;
         cnt <= BAUD_DIV - 1;
      end else begin
         // no parity bit: a low stop bit drops the byte
         rxByte <= sh;
         rxStrobe <= rxLine;
         bitNo <= -1;
      end
   end
endmodule : fpm_serial_rx

//--- test/fpm_mapper_bench.sv
// bench of the mapper: images per mode, serial line, control byte
// assumes the mapper, its fifo and the serial receiver model
`timescale 1ns/100ps
module fpm_mapper_bench;
   import fpm_pkg::*;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         ce = 1'b1;
   logic         triggerSel = 1'b0;
   logic         serialOutputSync = 1'b0;
   logic [2:0]   modeSel = 3'h1;
   logic [7:0]   ctrlIn = 8'h00;
   logic         ctrlWe = 1'b0;
   fpm_meas_s    meas = '0;
   fpm_ctl_s     ctl;
   logic [7:0]   controlByte, deviceStatusByte, imgData, rxByte;
   logic [7:0]   b, e, st, prev = 8'h00;
   logic         imgValid, imgLast, serialTx, rxStrobe;
   logic [7:0]   expQ[$], gotQ[$], rxQ[$];
   logic [223:0] raw;
   int           failures = 0, checks_done = 0, cycles = 0;
   int           clrCnt = 0, rstCnt = 0, expClr = 0, expRst = 0;
   integer       seed = 32'hb81b;

   fpm_mapper dut (.clk, .rst_b, .ce, .modeSel, .triggerSel,
      .serialOutputSync, .ctrlIn, .ctrlWe, .meas, .ctl, .controlByte,
      .deviceStatusByte, .imgData, .imgValid, .imgLast, .serialTx);
   fpm_serial_rx link (.clk, .rst_b, .rxLine(serialTx), .rxByte,
      .rxStrobe);

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (imgValid === 1'b1)
         gotQ.push_back(imgData);
      if (rxStrobe === 1'b1)
         rxQ.push_back(rxByte);
      if (ctl.clearErr === 1'b1)
         clrCnt++;
      if (ctl.restore === 1'b1)
         rstCnt++;
      // the whole run needs about 56000 cycles
      if (cycles == 90000) begin
         failures++;
         print_verdict();
      end
   end

   task tick;
      @(posedge clk);
      #2;
   endtask : tick
   task chk(string what, logic [7:0] exp, logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task put(logic [31:0] v, int n);
      for (int i = n - 1; i >= 0; i--)
         expQ.push_back(v[8*i +: 8]);
   endtask : put
   task build(logic [2:0] m);
      expQ.delete();
      put(32'(meas.counter), 2);
      put(meas.velocity, 4);
      put(32'(meas.rate), 2);
      if (m == 3'h2) begin
         put(meas.integral, 4);
         put(meas.msTimer, 4);
      end
      if (m >= 3'h4 && m <= 3'h6)
         put(meas.length[31:0], 4);
      if (m == 3'h3 || m == 3'h5) begin
         put(32'(meas.illum), 1);
         put(32'(meas.exposure), 1);
      end
      if (m == 3'h6) begin
         put(32'(meas.errCode), 1);
         put(32'(st), 1);
         put(32'(meas.temp), 1);
      end
   endtask : build
   task restart(logic [2:0] m, logic s);
      modeSel = m;
      serialOutputSync = s;
      for (int i = 0; i < 7; i++)
         raw = {raw[191:0], 32'($random(seed))};
      meas = raw[211:0];
      st = {4'h0, meas.lenNeg, meas.velNeg, meas.sigOk, meas.errFlag};
      rst_b = 1'b0;
      tick();
      tick();
      rst_b = 1'b1;
      gotQ.delete();
      build((m == 3'h0 || m == 3'h7) ? 3'h1 : m);
   endtask : restart
   task cmpImg;
      repeat (40) tick();
      chk("image length", 8'(expQ.size()), 8'(gotQ.size()));
      foreach (expQ[i])
         chk("image byte", expQ[i], gotQ[i]);
      chk("status", st, deviceStatusByte);
   endtask : cmpImg
   task wr(logic [7:0] v);
      ctrlIn = v;
      ctrlWe = 1'b1;
      tick();
      ctrlWe = 1'b0;
      ctrlIn = ~v;
      tick();
      tick();
   endtask : wr
   task print_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   initial begin
      restart(3'h1, 1'b0);
      cmpImg();
      for (int i = 0; i < 60000 && rxQ.size() < 8; i++)
         tick();
      foreach (expQ[i])
         chk("serial byte", expQ[i], rxQ[i]);
      for (int m = 0; m < 8; m++) begin
         restart(3'(m), 1'b0);
         cmpImg();
      end
      for (int t = 0; t < 2; t++) begin
         triggerSel = t[0];
         for (int k = 0; k < 24; k++) begin
            b = 8'($random(seed));
            if (prev[7])
               b[7] = 1'b0;
            expClr += int'(b[4] && !prev[4]);
            expRst += int'(b[7] && !prev[7]);
            e = {t[0] ? b[0] : b[2], b[1], b[3], t[0] & b[2], 2'b00, b[6:5]};
            wr(b);
            chk("readback", b, controlByte);
            chk("actions", e, ctl);
            prev = b;
         end
      end
      chk("clear pulses", 8'(expClr), 8'(clrCnt));
      chk("restore pulses", 8'(expRst), 8'(rstCnt));
      ce = 1'b0; // a write while frozen must not land
      wr(~prev);
      ce = 1'b1;
      chk("frozen control", prev, controlByte);
      triggerSel = 1'b0;
      restart(3'h4, 1'b1);
      wr(8'h04);
      wr(8'h0C);
      repeat (40) tick();
      chk("standby frames", 8'h00, 8'(gotQ.size()));
      wr(8'h00);
      wr(8'h08);
      cmpImg();
      triggerSel = 1'b1;
      restart(3'h6, 1'b1);
      wr(8'h04);
      cmpImg();
      print_verdict();
   end
endmodule : fpm_mapper_bench
